// [stp_dev.sv]
// Sensor end: SMBus slave register port plus conversion sequencer.
// Assumes conversion results arrive from logic on clk; link pins async.
//
// Behaviour
// - All registers are eight bits wide
// - One slave address reaches every register
// - Write, read, send and receive byte only
// - Receive byte returns last pointed register
// - Multi-master hosts avoid short forms
// - Channel one reports eleven bits, 0.125 LSB
// - Other channels report whole degrees
// - Upper eight bits main, three bits extended
// - Fraction in top three extended bits
// - Host reads extended byte before high byte
// - Extended read freezes matching high byte
// - Freeze ends after one bus timeout
// - High byte clamps to 0..127
// - Shorted diode reads EEh
// - Open diode sets fault, stores FFh
// - Fault found in 4 ms, sequencer moves on
// - Read byte: command, repeated start, nack
// - Register pointer resets to zero
// - Config bit five disables bus timeout
`timescale 1ns/10ps
`default_nettype none
module stp_dev
    import stp_pkg::*;
#(
    parameter int TMO_CYCLES = TMO_CYC,
    parameter int FLT_CYCLES = FLT_CYC
) (
    input  wire logic               clk,
    input  wire logic               arst_n,
    stp_smbus_if.dev                bus,
    output logic                    conv_start,
    output logic [2:0]              conv_chan,
    input  wire logic               conv_done,
    input  wire logic signed [11:0] conv_temp,
    input  wire logic               conv_open,
    input  wire logic               conv_short
);
    typedef enum {S_IDLE, S_ADDR, S_AACK, S_CMD, S_CACK, S_WDAT, S_WACK,
                  S_RDAT, S_RACK} stp_bus_st_t;
    typedef enum {Q_GO, Q_WAIT} stp_seq_st_t;

    logic [1:0]  scl_s_q;
    logic [1:0]  sda_s_q;
    logic        scl_p_q;
    logic        sda_p_q;
    stp_bus_st_t st_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q;
    logic        rw_q;
    logic        nak_q;
    logic        drv_q;
    logic [7:0]  ptr_q;
    logic [7:0]  cfg1_q;
    logic [7:0]  cfg2_q;
    logic [31:0] tmo_q;
    logic        frz_q;
    logic [31:0] frz_cnt_q;
    logic [7:0]  temp_q [1:7];
    logic [7:1]  flt_q;
    logic [7:0]  ext_q;
    stp_seq_st_t q_st_q;
    logic [2:0]  seq_q;
    logic        alt_q;
    logic [31:0] fcnt_q;
    logic        scl_rise, scl_fall, start_c, stop_c, tmo_hit;
    logic        cmd_take, data_take, rd_take;
    logic        res_ev, res_open, res_short, fto;
    logic [7:0]  rd_mux;
    logic [7:0]  hb;

    // Two-stage synchronisers, then a third stage for edge detection
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], bus.scl};
            sda_s_q <= {sda_s_q[0], bus.sda};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end

    // Link events
    assign scl_rise = scl_s_q[1] & ~scl_p_q;
    assign scl_fall = ~scl_s_q[1] & scl_p_q;
    assign start_c  = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    assign stop_c   = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
    assign tmo_hit  = (tmo_q == TMO_CYCLES - 1) & ~cfg1_q[CFG1_TMODIS];
    assign cmd_take  = scl_fall & (st_q == S_CMD) & (cnt_q == 4'h8);
    assign data_take = scl_fall & (st_q == S_WDAT) & (cnt_q == 4'h8);
    assign rd_take   = scl_fall & (((st_q == S_AACK) & rw_q) |
                                   ((st_q == S_RACK) & ~nak_q));

    // Open-drain data: only ever pulls low
    assign bus.d_sda_o    = 1'b0;
    assign bus.d_sda_oe_n = ~drv_q;

    // Byte-level slave sequencing; ack driven for the whole ninth clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q  <= S_IDLE;
            cnt_q <= 4'h0;
            sh_q  <= 8'h00;
            rw_q  <= 1'b0;
            nak_q <= 1'b0;
            drv_q <= 1'b0;
        end else if (start_c) begin
            st_q  <= S_ADDR;
            cnt_q <= 4'h0;
            drv_q <= 1'b0;
        end else if (stop_c || tmo_hit) begin
            st_q  <= S_IDLE;
            drv_q <= 1'b0;
        end else if (scl_rise) begin
            if ((st_q == S_ADDR || st_q == S_CMD || st_q == S_WDAT) &&
                cnt_q != 4'h8) begin
                sh_q  <= {sh_q[6:0], sda_s_q[1]};
                cnt_q <= cnt_q + 4'h1;
            end
            if (st_q == S_RACK)
                nak_q <= sda_s_q[1];
        end else if (scl_fall) begin
            case (st_q)
                S_ADDR: if (cnt_q == 4'h8) begin
                    if (sh_q[7:1] == DEV_ADDR) begin
                        st_q  <= S_AACK;
                        drv_q <= 1'b1;
                        rw_q  <= sh_q[0];
                    end else begin
                        st_q <= S_IDLE;                 // Not ours
                    end
                end
                S_AACK: begin
                    cnt_q <= 4'h0;
                    if (rw_q) begin
                        st_q  <= S_RDAT;
                        sh_q  <= rd_mux;
                        drv_q <= ~rd_mux[7];
                    end else begin
                        st_q  <= S_CMD;
                        drv_q <= 1'b0;
                    end
                end
                S_CMD, S_WDAT: if (cnt_q == 4'h8) begin
                    st_q  <= (st_q == S_CMD) ? S_CACK : S_WACK;
                    drv_q <= 1'b1;
                end
                S_CACK, S_WACK: begin
                    st_q  <= S_WDAT;
                    cnt_q <= 4'h0;
                    drv_q <= 1'b0;
                end
                S_RDAT: begin
                    if (cnt_q == 4'h7) begin
                        st_q  <= S_RACK;
                        drv_q <= 1'b0;
                    end else begin
                        sh_q  <= {sh_q[6:0], 1'b0};
                        drv_q <= ~sh_q[6];
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                S_RACK: begin
                    if (!nak_q) begin                   // Acked: resend
                        st_q  <= S_RDAT;
                        sh_q  <= rd_mux;
                        drv_q <= ~rd_mux[7];
                        cnt_q <= 4'h0;
                    end else begin
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Bus timeout: clock held low mid-transfer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            tmo_q <= 32'h0;
        else if (st_q == S_IDLE || scl_s_q[1] || tmo_hit)
            tmo_q <= 32'h0;
        else
            tmo_q <= tmo_q + 32'h1;
    end

    // Pointer and writable configuration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_q  <= PTR_RST;
            cfg1_q <= CFG_RST;
            cfg2_q <= CFG_RST;
        end else begin
            if (cmd_take)
                ptr_q <= sh_q;
            if (data_take && ptr_q == REG_CFG1)
                cfg1_q <= sh_q;
            if (data_take && ptr_q == REG_CFG2)
                cfg2_q <= sh_q;
        end
    end

    // Read data selection; unmapped pointers read zero
    always_comb begin
        rd_mux = 8'h00;
        case (ptr_q)
            REG_EXT1:  rd_mux = ext_q;
            REG_CFG1:  rd_mux = cfg1_q;
            REG_CFG2:  rd_mux = cfg2_q;
            REG_FAULT: rd_mux = {2'h0, flt_q[6:1]};
            default:
                if (ptr_q >= REG_CH1 && ptr_q <= REG_LOCAL)
                    rd_mux = temp_q[ptr_q[2:0]];
        endcase
    end

    // High-byte freeze after an extended-byte read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            frz_q <= 1'b0;
        else if (rd_take && ptr_q == REG_EXT1)
            frz_q <= 1'b1;
        else if ((rd_take && ptr_q == REG_CH1) ||
                 frz_cnt_q == TMO_CYCLES - 1)
            frz_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            frz_cnt_q <= 32'h0;
        else if (!frz_q || rd_take)
            frz_cnt_q <= 32'h0;
        else
            frz_cnt_q <= frz_cnt_q + 32'h1;
    end

    // Conversion sequencer; a stop aborts without updating results
    assign fto       = (fcnt_q == FLT_CYCLES - 1) & ~conv_done;
    assign res_ev    = (q_st_q == Q_WAIT) & ~cfg1_q[CFG1_STOP] &
                       (conv_done | fto);
    assign res_open  = fto | (conv_done & conv_open);
    assign res_short = conv_done & conv_short & ~conv_open;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_st_q     <= Q_GO;
            seq_q      <= 3'h0;
            alt_q      <= 1'b0;
            fcnt_q     <= 32'h0;
            conv_start <= 1'b0;
            conv_chan  <= REG_CH1[2:0];
        end else begin
            conv_start <= 1'b0;
            case (q_st_q)
                Q_GO: if (!cfg1_q[CFG1_STOP]) begin
                    if (cfg1_q[CFG1_FAST] && !alt_q)
                        conv_chan <= REG_CH1[2:0];
                    else
                        conv_chan <= (seq_q == 3'h3) ? REG_LOCAL[2:0] :
                                     (seq_q < 3'h3) ? seq_q + 3'h1 : seq_q;
                    conv_start <= 1'b1;
                    fcnt_q     <= 32'h0;
                    q_st_q     <= Q_WAIT;
                end
                Q_WAIT: begin
                    fcnt_q <= fcnt_q + 32'h1;
                    if (cfg1_q[CFG1_STOP]) begin
                        q_st_q <= Q_GO;
                    end else if (res_ev) begin
                        q_st_q <= Q_GO;
                        if (cfg1_q[CFG1_FAST] && !alt_q) begin
                            alt_q <= 1'b1;
                        end else begin
                            alt_q <= 1'b0;
                            if (seq_q == 3'h6)
                                seq_q <= {2'h0, cfg1_q[CFG1_FAST]};
                            else
                                seq_q <= seq_q + 3'h1;
                        end
                    end
                end
                default: q_st_q <= Q_GO;
            endcase
        end
    end

    // Result to high-byte code
    always_comb begin
        hb = {1'b0, conv_temp[9:3]};
        if (res_open)
            hb = HB_OPEN;
        else if (res_short)
            hb = HB_SHORT;
        else if (conv_temp[11])
            hb = HB_ZERO;
        else if (conv_temp[10])
            hb = HB_MAX;
    end

    // Per-channel result storage; channel one honours the freeze
    for (genvar c = 1; c <= 7; c++) begin : g_ch
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                temp_q[c] <= 8'h00;
                flt_q[c]  <= 1'b0;
            end else if (res_ev && conv_chan == 3'(c)) begin
                if (!(c == 1 && frz_q))
                    temp_q[c] <= hb;
                flt_q[c] <= res_open | res_short;
            end
        end
    end

    // Extended byte: three fraction bits on top, rest zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ext_q <= 8'h00;
        else if (res_ev && conv_chan == REG_CH1[2:0])
            ext_q <= (hb == {1'b0, conv_temp[9:3]}) ?
                     {conv_temp[2:0], 5'h00} : 8'h00;
    end
endmodule
`default_nettype wire

// [stp_pkg.sv]
// Shared constants for the SMBus temperature register port.
// Assumes a 100 MHz system clock on both ends of the link.
package stp_pkg;
    // Clock and link timing
    localparam int CLK_KHZ = 100_000;
    localparam int TMO_MS  = 37;               // Bus and freeze timeout
    localparam int TMO_CYC = TMO_MS * CLK_KHZ;
    localparam int FLT_MS  = 4;                // Diode fault detection time
    localparam int FLT_CYC = FLT_MS * CLK_KHZ;
    localparam int SCL_KHZ = 100;
    localparam int QTR_CYC = CLK_KHZ / (4 * SCL_KHZ);

    // Slave address, arbitrary value
    localparam logic [6:0] DEV_ADDR = 7'h2C;

    // Register pointer values
    localparam logic [7:0] PTR_RST   = 8'h00;
    localparam logic [7:0] REG_CH1   = 8'h01;
    localparam logic [7:0] REG_LOCAL = 8'h07;
    localparam logic [7:0] REG_EXT1  = 8'h11;
    localparam logic [7:0] REG_CFG1  = 8'h41;
    localparam logic [7:0] REG_CFG2  = 8'h42;
    localparam logic [7:0] REG_FAULT = 8'h4A;
    localparam logic [7:0] CFG_RST   = 8'h00;

    // Configuration 1 bit positions
    localparam int CFG1_STOP   = 7;
    localparam int CFG1_TMODIS = 5;
    localparam int CFG1_FAST   = 4;

    // High-byte codes
    localparam logic [7:0] HB_OPEN  = 8'hFF;
    localparam logic [7:0] HB_SHORT = 8'hEE;
    localparam logic [7:0] HB_MAX   = 8'h7F;
    localparam logic [7:0] HB_ZERO  = 8'h00;

    // Host controller register map and fields
    localparam logic [3:0] HOST_CMD  = 4'h0;
    localparam logic [3:0] HOST_STAT = 4'h4;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_KIND_LSB = 16;
    localparam int STAT_BUSY    = 8;
    localparam int STAT_NACK    = 9;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {XF_WRITE, XF_READ, XF_SEND, XF_RECV}
        stp_xfer_t;
endpackage

// [stp_smbus_if.sv]
// Two-wire link between the host controller and the sensor port.
// Assumes pull-ups on both lines: a line is low only where driven low.
`timescale 1ns/10ps
`default_nettype none
interface stp_smbus_if;
    logic h_scl_o;
    logic h_scl_oe_n;
    logic h_sda_o;
    logic h_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic scl;
    logic sda;

    // Wired-AND of the open-drain drivers
    assign scl = h_scl_oe_n | h_scl_o;
    assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);

    modport dev  (input scl, sda, output d_sda_o, d_sda_oe_n);
    modport host (input scl, sda,
                  output h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n);
endinterface
`default_nettype wire

// [stp_host.sv]
// Host end: SMBus master driven by an AXI4-Lite register pair.
// Assumes software polls the status word for completion.
`timescale 1ns/10ps
`default_nettype none
module stp_host
    import stp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [3:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [3:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    stp_smbus_if.host        bus
);
    typedef enum logic [1:0] {G_S, G_TX, G_RX, G_P} stp_seg_t;

    logic        aw_q, w_q, wr_go, go;
    logic [3:0]  awa_q;
    logic [31:0] wd32_q;
    logic [3:0]  ws_q;
    stp_xfer_t   kind_q;
    logic [7:0]  reg_q, wd_q, rdb_q;
    logic        busy_q, nack_q;
    logic [2:0]  seg_q;
    logic [3:0]  bit_q;
    logic [1:0]  ph_q;
    logic [15:0] qc_q;
    logic        tick, scl_q, sda_q;
    logic [1:0]  sda_s_q;
    stp_seg_t    sg;
    logic [7:0]  tb;

    // Write channel: address and data taken in either order
    assign awready = ~aw_q;
    assign wready  = ~w_q;
    assign wr_go   = aw_q & w_q & ~bvalid;
    assign go      = wr_go & (awa_q == HOST_CMD) & ~busy_q & (&ws_q[2:0]);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_q   <= 1'b0;
            w_q    <= 1'b0;
            awa_q  <= 4'h0;
            wd32_q <= 32'h0;
            ws_q   <= 4'h0;
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else begin
            if (awvalid && !aw_q) begin
                aw_q  <= 1'b1;
                awa_q <= awaddr;
            end
            if (wvalid && !w_q) begin
                w_q    <= 1'b1;
                wd32_q <= wdata;
                ws_q   <= wstrb;
            end
            if (wr_go) begin
                aw_q   <= 1'b0;
                w_q    <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= (awa_q == HOST_CMD || awa_q == HOST_STAT) ?
                          RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read channel, one cycle to rvalid
    assign arready = ~rvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            rdata  <= 32'h0;
            if (araddr == HOST_STAT)
                rdata <= {22'h0, nack_q, busy_q, rdb_q};
            else if (araddr == HOST_CMD)
                rdata <= {14'h0, kind_q, wd_q, reg_q};
            else
                rresp <= RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Data line synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            sda_s_q <= 2'h3;
        else
            sda_s_q <= {sda_s_q[0], bus.sda};
    end

    // Quarter-bit timebase; SCL is divided from clk here
    assign tick = busy_q & (qc_q == 16'(QTR_CYC - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            qc_q <= 16'h0;
        else if (!busy_q || tick)
            qc_q <= 16'h0;
        else
            qc_q <= qc_q + 16'h1;
    end

    // Segment plan for each transfer type
    always_comb begin
        sg = G_P;
        tb = {DEV_ADDR, 1'b0};
        case (seg_q)
            3'h0: sg = G_S;
            3'h1: begin
                sg = G_TX;
                if (kind_q == XF_RECV)
                    tb = {DEV_ADDR, 1'b1};
            end
            3'h2: begin
                sg = (kind_q == XF_RECV) ? G_RX : G_TX;
                tb = reg_q;
            end
            3'h3: begin
                if (kind_q == XF_WRITE) begin
                    sg = G_TX;
                    tb = wd_q;
                end else if (kind_q == XF_READ) begin
                    sg = G_S;
                end
            end
            3'h4: if (kind_q == XF_READ) begin
                sg = G_TX;
                tb = {DEV_ADDR, 1'b1};
            end
            3'h5: if (kind_q == XF_READ)
                sg = G_RX;
            default: sg = G_P;
        endcase
    end

    assign bus.h_scl_o    = 1'b0;
    assign bus.h_sda_o    = 1'b0;
    assign bus.h_scl_oe_n = scl_q;
    assign bus.h_sda_oe_n = sda_q;

    // Bit engine: p0 set data, p1 raise clock, p2 sample, p3 lower
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            nack_q <= 1'b0;
            kind_q <= XF_WRITE;
            reg_q  <= 8'h00;
            wd_q   <= 8'h00;
            rdb_q  <= 8'h00;
            seg_q  <= 3'h0;
            bit_q  <= 4'h0;
            ph_q   <= 2'h0;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
        end else if (go) begin
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            reg_q  <= wd32_q[7:0];
            wd_q   <= wd32_q[CMD_DATA_LSB +: 8];
            kind_q <= stp_xfer_t'(wd32_q[CMD_KIND_LSB +: 2]);
            seg_q  <= 3'h0;
            bit_q  <= 4'h0;
            ph_q   <= 2'h0;
        end else if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
                2'h0: sda_q <= (sg == G_S) | (sg == G_RX) |
                               ((sg == G_TX) &
                                ((bit_q == 4'h8) | tb[3'(7 - bit_q)]));
                2'h1: scl_q <= 1'b1;
                2'h2: begin
                    if (sg == G_S)
                        sda_q <= 1'b0;
                    else if (sg == G_P)
                        sda_q <= 1'b1;
                    else if (sg == G_TX && bit_q == 4'h8)
                        nack_q <= sda_s_q[1];
                    else if (sg == G_RX && bit_q != 4'h8)
                        rdb_q <= {rdb_q[6:0], sda_s_q[1]};
                end
                default: begin
                    if (sg == G_P) begin
                        busy_q <= 1'b0;
                    end else begin
                        scl_q <= 1'b0;
                        if (sg == G_S || bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            seg_q <= nack_q ? 3'h7 : seg_q + 3'h1;
                        end else begin
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [stp_assertions.sv]
// Checker for link timing and conversion sequencing of the sensor port.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module stp_assertions (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       scl,
    input wire logic       d_sda_oe_n,
    input wire logic       conv_start,
    input wire logic [2:0] conv_chan,
    input wire logic       conv_done
);
    localparam int GAP_MAX = 210;
    localparam logic [2:0] NXT [8] = '{3'h1, 3'h2, 3'h3, 3'h7,
                                       3'h5, 3'h6, 3'h1, 3'h4};
    logic [2:0] last_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Channel of the last start; zero means none yet
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            last_q <= 3'h0;
        else if (conv_start)
            last_q <= conv_chan;
    end
    sequence s_restart;
        ##2 conv_start;
    endsequence
    AST_DEV_SDA_ON_LOW: assert property ($changed(d_sda_oe_n) |-> !scl)
        else $error("device data moved while clock high");
    AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high phase too short");
    AST_SCL_LOW_MIN: assert property ($fell(scl) |-> (!scl)[*8])
        else $error("clock low phase too short");
    AST_START_PULSE: assert property (conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    AST_DONE_RESTART: assert property (conv_done |-> s_restart)
        else $error("no start two cycles after result");
    AST_CHAN_ORDER: assert property (conv_start |-> conv_chan == NXT[last_q])
        else $error("channel out of sequence");
    AST_START_GAP: assert property (conv_start |=> ##[1:GAP_MAX] conv_start)
        else $error("sequencer stalled on a channel");
    AST_CHAN_HELD: assert property ($changed(conv_chan) |-> conv_start)
        else $error("channel changed without start");
endmodule
`default_nettype wire

// [tb_top.sv]
// Bench joining host controller and sensor port over the link.
// Assumes package and interface compiled first; 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import stp_pkg::*;
;
    logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic conv_start, conv_done, conv_open, conv_short;
    logic [3:0] awaddr, araddr;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] wdata, rdata, rd;
    logic [2:0] conv_chan, ch;
    logic [7:0] t0;
    logic signed [11:0] conv_temp;
    logic signed [11:0] tmp [1:7];
    int fails, checks, seed, cd;
    stp_smbus_if stp_smbus_if_inst ();
    stp_host stp_host_inst (.clk(clk), .arst_n(arst_n), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .bus(stp_smbus_if_inst.host));
    stp_dev #(.TMO_CYCLES(60000), .FLT_CYCLES(200)) stp_dev_inst (.clk(clk),
        .arst_n(arst_n), .bus(stp_smbus_if_inst.dev), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_temp(conv_temp),
        .conv_open(conv_open), .conv_short(conv_short));
    stp_assertions stp_assertions_inst (.clk(clk), .arst_n(arst_n),
        .scl(stp_smbus_if_inst.scl), .d_sda_oe_n(stp_smbus_if_inst.d_sda_oe_n),
        .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Converter stand-in: channel 5 stays silent so the fault timer runs
    always @(posedge clk) begin
        conv_done <= 1'b0;
        if (conv_start) begin
            ch <= conv_chan;
            cd <= (conv_chan == 3'h5) ? 0 : 2 + ($random(seed) & 15);
        end else if (cd > 0) begin
            cd <= cd - 1;
            conv_done <= (cd == 1);
            conv_temp <= tmp[ch];
            conv_short <= (ch == 3'h3);
            conv_open <= (ch == 3'h6);
        end
    end
    function automatic logic [7:0] hb(input logic signed [11:0] t);
        if (t < 0)
            return HB_ZERO;
        if (t > 12'sh3FF)
            return HB_MAX;
        return t[10:3];
    endfunction
    task automatic chk(input string n, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // One AXI transfer; valid held until its own ready edge
    task automatic axi(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        logic ta, tw, tr, tz;
        @(posedge clk);
        awvalid <= wr;
        wvalid <= wr;
        arvalid <= !wr;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        bready <= wr;
        rready <= !wr;
        for (int i = 0; i < 50; i++) begin
            @(negedge clk);
            ta = awready;
            tw = wready;
            tr = arready;
            tz = (bvalid & bready) | (rvalid & rready);
            rd = rdata;
            rs = wr ? bresp : rresp;
            @(posedge clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (tr)
                arvalid <= 1'b0;
            if (tz) begin
                bready <= 1'b0;
                rready <= 1'b0;
                return;
            end
        end
        fails++;
        report_and_stop();
    endtask
    // Launch a link transfer, then poll status until idle
    task automatic smb(input logic [1:0] k, input logic [7:0] c);
        axi(1'b1, HOST_CMD, {14'h0, k, 8'h00, c});
        for (int i = 0; i < 400; i++) begin
            repeat (200) @(posedge clk);
            axi(1'b0, HOST_STAT, 32'h0);
            if (rd[STAT_BUSY] === 1'b0)
                return;
        end
        fails++;
        report_and_stop();
    endtask
    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 40'h0;
        {conv_done, conv_open, conv_short, conv_temp} = 15'h0;
        {fails, checks, cd} = 96'h0;
        seed = 32'h134C;
        foreach (tmp[i]) tmp[i] = $random(seed);
        tmp[1] = $random(seed) & 12'h3FF;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        axi(1'b0, 4'h8, 32'h0);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        smb(XF_READ, REG_EXT1);
        chk("fraction", {29'h0, tmp[1][2:0]}, {29'h0, rd[7:5]});
        chk("nack flag", 32'h0, {31'h0, rd[STAT_NACK]});
        $display("test extended read done");
        t0 = hb(tmp[1]);
        tmp[1] = 12'sh640;
        smb(XF_READ, REG_CH1);
        chk("frozen high byte", {24'h0, t0}, {24'h0, rd[7:0]});
        $display("test frozen read done");
        smb(XF_RECV, 8'h00);
        chk("receive byte", {24'h0, HB_MAX}, {24'h0, rd[7:0]});
        $display("test receive byte done");
        report_and_stop();
    end
    task report_and_stop;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
endmodule
`default_nettype wire
